// *** src/nds_pkg.sv ***
package nds_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FLOOR_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_REV_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_FB_BIT = 4;
    localparam int CTRL_TA_LSB = 8;
    // Reset values and the angle setting limit
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic CTRL_REV_RST = 1'b0;
    localparam logic CTRL_FB_RST = 1'b1;
    localparam logic signed [7:0] TA_RST = -8'sd45;
    localparam logic [8:0] FLOOR_RST = 9'h032;
    localparam logic signed [7:0] TA_MAX = 8'sd90;
    // Magnitude floors, currents at 1 mA per LSB, squared
    localparam logic [39:0] OP_MIN_SQ = 40'h00_0000_09c4;
    localparam logic [39:0] POL_I_MIN_SQ = 40'h00_0000_0019;
    // cos^2(85 deg) in Q16
    localparam logic [95:0] COS2_85_Q16 = 96'h1f2;
    localparam int COS2_FRAC = 16;
    // Parabolic cosine approximation constant, 180^2
    localparam logic [31:0] PARA_K = 32'h0000_7e90;
    localparam int TRIG_FRAC = 15;
    // Polarizing settle time
    localparam int POL_TIME_MS = 20;
    localparam int CLK_KHZ = 250000;
    localparam int POL_CYCLES = POL_TIME_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        NDS_POL_V = 2'h0,
        NDS_POL_I = 2'h1,
        NDS_POL_EITHER = 2'h2,
        NDS_POL_BOTH = 2'h3
    } nds_pol_e;
endpackage

// *** src/nds_top.sv ***
`timescale 1ns/1ps
module nds_top #(
    parameter int POL_CYCLES = nds_pkg::POL_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] phase_a_re,
    input wire logic signed [15:0] phase_a_im,
    input wire logic signed [15:0] phase_b_re,
    input wire logic signed [15:0] phase_b_im,
    input wire logic signed [15:0] phase_c_re,
    input wire logic signed [15:0] phase_c_im,
    input wire logic signed [15:0] zero_sequence_voltage_re,
    input wire logic signed [15:0] zero_sequence_voltage_im,
    input wire logic signed [15:0] polarizing_current_re,
    input wire logic signed [15:0] polarizing_current_im,
    output logic neutral_direction_permit,
    output logic neutral_direction_inhibited,
    output logic neutral_direction_forward
);
    logic en_reg;
    logic rev_reg;
    logic fb_reg;
    nds_pkg::nds_pol_e mode_reg;
    logic signed [7:0] ta_reg;
    logic [8:0] floor_reg;
    logic [31:0] pol_cnt_reg;
    logic polarized_reg;
    logic v_fwd_reg;
    logic i_fwd_reg;
    logic op_low_reg;

    // Magnitudes stay squared so no square root is needed
    function automatic logic [39:0] mag_sq(input logic signed [19:0] re,
                                           input logic signed [19:0] im);
        logic signed [39:0] s;
        s = 40'(re * re) + 40'(im * im);
        return s;
    endfunction

    // True when the angle between a and b is under 85 degrees
    // Cross-multiplied cosine test, so the angle path needs no divider
    function automatic logic within_85(input logic signed [19:0] ar,
                                       input logic signed [19:0] ai,
                                       input logic signed [19:0] br,
                                       input logic signed [19:0] bi);
        logic signed [40:0] dot;
        logic [95:0] lhs;
        logic [95:0] rhs;
        dot = 41'(ar * br) + 41'(ai * bi);
        lhs = 96'(dot * dot) << nds_pkg::COS2_FRAC;
        rhs = 96'(mag_sq(ar, ai)) * 96'(mag_sq(br, bi)) * nds_pkg::COS2_85_Q16;
        return (dot > 41'sd0) && (lhs > rhs);
    endfunction

    // Parabolic approximation, cos in Q15 for 0..90 degrees
    function automatic logic signed [16:0] cos_q15(input logic [6:0] deg);
        logic [31:0] x2;
        logic [31:0] num;
        logic [31:0] den;
        x2 = 32'(deg) * 32'(deg);
        num = nds_pkg::PARA_K - (x2 << 2);
        den = nds_pkg::PARA_K + x2;
        return 17'((num << nds_pkg::TRIG_FRAC) / den);
    endfunction

    // Phasor arithmetic
    logic signed [19:0] in_re;
    logic signed [19:0] in_im;
    logic signed [19:0] ref_re;
    logic signed [19:0] ref_im;
    logic signed [19:0] ip_re;
    logic signed [19:0] ip_im;
    logic signed [19:0] rot_re;
    logic signed [19:0] rot_im;
    logic signed [7:0] ta_clip;
    logic [6:0] ta_abs;
    logic signed [16:0] c_q;
    logic signed [16:0] s_q;
    logic signed [37:0] rr_w;
    logic signed [37:0] ri_w;

    assign in_re = 20'(phase_a_re) + 20'(phase_b_re) + 20'(phase_c_re);
    assign in_im = 20'(phase_a_im) + 20'(phase_b_im) + 20'(phase_c_im);
    assign ref_re = -20'(zero_sequence_voltage_re);
    assign ref_im = -20'(zero_sequence_voltage_im);
    assign ip_re = 20'(polarizing_current_re);
    assign ip_im = 20'(polarizing_current_im);
    // Out-of-range settings clip to the documented +/-90 degrees
    assign ta_clip = (ta_reg > nds_pkg::TA_MAX) ? nds_pkg::TA_MAX :
                     (ta_reg < -nds_pkg::TA_MAX) ? -nds_pkg::TA_MAX : ta_reg;
    assign ta_abs = ta_clip[7] ? 7'(-ta_clip) : 7'(ta_clip);
    assign c_q = cos_q15(ta_abs);
    assign s_q = ta_clip[7] ? -cos_q15(7'(7'd90 - ta_abs)) : cos_q15(7'(7'd90 - ta_abs));
    // Counter-clockwise rotation for positive angles
    assign rr_w = 38'(ref_re * c_q) - 38'(ref_im * s_q);
    assign ri_w = 38'(ref_re * s_q) + 38'(ref_im * c_q);
    assign rot_re = 20'(rr_w >>> nds_pkg::TRIG_FRAC);
    assign rot_im = 20'(ri_w >>> nds_pkg::TRIG_FRAC);

    // Quality checks and per-source decisions
    logic op_low;
    logic v_above;
    logic v_ok;
    logic i_ok;
    logic v_fwd;
    logic i_fwd;
    logic v_match;
    logic i_match;
    logic need_v;
    logic need_i;
    logic inh_next;
    logic dir_next;
    logic permit_next;
    logic [39:0] floor_sq;

    assign floor_sq = 40'(floor_reg) * 40'(floor_reg);
    assign op_low = mag_sq(in_re, in_im) < nds_pkg::OP_MIN_SQ;
    assign v_above = mag_sq(ref_re, ref_im) >= floor_sq;
    assign v_ok = v_above && polarized_reg;
    assign i_ok = mag_sq(ip_re, ip_im) >= nds_pkg::POL_I_MIN_SQ;
    assign v_fwd = within_85(in_re, in_im, rot_re, rot_im);
    assign i_fwd = within_85(in_re, in_im, ip_re, ip_im);
    assign v_match = v_fwd ^ rev_reg;
    assign i_match = i_fwd ^ rev_reg;
    assign need_v = (mode_reg != nds_pkg::NDS_POL_I);
    assign need_i = (mode_reg != nds_pkg::NDS_POL_V);
    assign inh_next = op_low || (need_v && !v_ok) || (need_i && !i_ok);

    always_comb begin
        dir_next = v_fwd;
        permit_next = v_match;
        case (mode_reg)
            nds_pkg::NDS_POL_V: begin
                dir_next = v_fwd;
                permit_next = v_match;
            end
            nds_pkg::NDS_POL_I: begin
                dir_next = i_fwd;
                permit_next = i_match;
            end
            nds_pkg::NDS_POL_EITHER: begin
                dir_next = v_fwd || i_fwd;
                permit_next = v_match || i_match;
            end
            nds_pkg::NDS_POL_BOTH: begin
                dir_next = v_fwd && i_fwd;
                permit_next = v_match && i_match;
            end
            default: begin
                dir_next = 1'b0;
                permit_next = 1'b0;
            end
        endcase
        if (inh_next) begin
            permit_next = fb_reg;
        end
    end

    // Settle timer: direction from voltage is not trusted until it has stood
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_cnt_reg <= 32'h0;
            polarized_reg <= 1'b0;
        end else if (ce) begin
            if (!v_above) begin
                pol_cnt_reg <= 32'h0;
                polarized_reg <= 1'b0;
            end else if (pol_cnt_reg < 32'(POL_CYCLES - 1)) begin
                pol_cnt_reg <= pol_cnt_reg + 32'h1;
            end else begin
                polarized_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neutral_direction_permit <= 1'b0;
            neutral_direction_inhibited <= 1'b0;
            neutral_direction_forward <= 1'b0;
            v_fwd_reg <= 1'b0;
            i_fwd_reg <= 1'b0;
            op_low_reg <= 1'b0;
        end else if (ce) begin
            v_fwd_reg <= v_fwd;
            i_fwd_reg <= i_fwd;
            op_low_reg <= op_low;
            if (!en_reg) begin
                neutral_direction_permit <= 1'b0;
                neutral_direction_inhibited <= 1'b0;
                neutral_direction_forward <= 1'b0;
            end else begin
                neutral_direction_permit <= permit_next;
                neutral_direction_inhibited <= inh_next;
                neutral_direction_forward <= dir_next && !inh_next;
            end
        end
    end

    // APB slave with one wait state so read data leaves a flip-flop
    logic access;
    logic hit;
    assign access = psel && penable && pready;
    assign hit = (paddr == nds_pkg::CTRL_OFS) || (paddr == nds_pkg::FLOOR_OFS) ||
                 (paddr == nds_pkg::STATUS_OFS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata <= 32'h0;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    nds_pkg::CTRL_OFS: begin
                        prdata <= {16'h0, 8'(ta_reg), 3'h0, fb_reg, 2'(mode_reg), rev_reg,
                                   en_reg};
                    end
                    nds_pkg::FLOOR_OFS: begin
                        prdata <= {23'h0, floor_reg};
                    end
                    nds_pkg::STATUS_OFS: begin
                        prdata <= {25'h0, op_low_reg, polarized_reg, i_fwd_reg, v_fwd_reg,
                                   neutral_direction_forward, neutral_direction_inhibited,
                                   neutral_direction_permit};
                    end
                    default: begin
                        prdata <= 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= nds_pkg::CTRL_EN_RST;
            rev_reg <= nds_pkg::CTRL_REV_RST;
            fb_reg <= nds_pkg::CTRL_FB_RST;
            mode_reg <= nds_pkg::NDS_POL_V;
            ta_reg <= nds_pkg::TA_RST;
            floor_reg <= nds_pkg::FLOOR_RST;
        end else if (ce && access && pwrite) begin
            if (paddr == nds_pkg::CTRL_OFS) begin
                en_reg <= pwdata[nds_pkg::CTRL_EN_BIT];
                rev_reg <= pwdata[nds_pkg::CTRL_REV_BIT];
                mode_reg <= nds_pkg::nds_pol_e'(pwdata[nds_pkg::CTRL_MODE_LSB +: 2]);
                fb_reg <= pwdata[nds_pkg::CTRL_FB_BIT];
                ta_reg <= pwdata[nds_pkg::CTRL_TA_LSB +: 8];
            end
            if (paddr == nds_pkg::FLOOR_OFS) begin
                floor_reg <= pwdata[8:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_disabled_outputs_low: assert property (
        ce && !en_reg |=> !neutral_direction_permit && !neutral_direction_inhibited)
        else $error("Disabled element drove an output");
    a_op_low_inhibits: assert property (
        ce && en_reg && op_low |=> neutral_direction_inhibited && !neutral_direction_forward)
        else $error("Low operating current was not inhibited");
    a_ip_low_inhibits: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_I && !i_ok |=> neutral_direction_inhibited)
        else $error("Low polarizing current was not inhibited");
    a_ip_low_fallback: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_I && !i_ok
        |=> neutral_direction_permit == $past(fb_reg))
        else $error("Fallback value not applied");
    a_pol_settle_wait: assert property (
        ce && !polarized_reg && pol_cnt_reg == 32'h0 |=> !polarized_reg)
        else $error("Voltage polarized before settle time");
    a_forward_permit: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_V && !inh_next && v_fwd && !rev_reg
        |=> neutral_direction_permit && neutral_direction_forward)
        else $error("Forward fault did not permit");
    a_reverse_select: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_I && !inh_next && rev_reg
        |=> neutral_direction_permit == !$past(i_fwd))
        else $error("Reverse setting not followed");
    a_both_needs_both: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_BOTH && !inh_next && !(v_match && i_match)
        |=> !neutral_direction_permit)
        else $error("Both mode permitted on one source");
    a_either_one_enough: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_EITHER && !inh_next && (v_match || i_match)
        |=> neutral_direction_permit)
        else $error("Either mode refused a matching source");
    a_apb_one_wait: assert property (
        ce && psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not one wait state");

    a_v_low_inhibits: assert property (
        ce && en_reg && mode_reg == nds_pkg::NDS_POL_V && !v_ok |=> neutral_direction_inhibited)
        else $error("Low polarizing voltage was not inhibited");
    a_inhibit_fallback: assert property (
        ce && en_reg && inh_next |=> neutral_direction_permit == $past(fb_reg))
        else $error("Inhibited permit did not follow fallback");
    a_settle_count: assert property (
        ce && !polarized_reg && pol_cnt_reg < 32'(POL_CYCLES - 1) |=> !polarized_reg)
        else $error("Voltage polarized before count completed");
    a_floor_write_lands: assert property (
        ce && psel && penable && pready && pwrite && paddr == nds_pkg::FLOOR_OFS
        |=> floor_reg == 9'($past(pwdata)))
        else $error("Floor write did not land");

    c_permit_forward: cover property (ce && en_reg && neutral_direction_permit &&
                                      !neutral_direction_inhibited);
    c_fallback_used: cover property (ce && en_reg && neutral_direction_inhibited &&
                                     neutral_direction_permit);
    c_polarized: cover property ($rose(polarized_reg));
    c_bad_address: cover property (pready && pslverr);
endmodule

// *** sim/nds_oc_partner.sv ***
`timescale 1ns/1ps
module nds_oc_partner (
    input wire logic permit,
    output logic timed_inhibit,
    output logic instant_inhibit
);
    // Both overcurrent elements may trip only while direction permits
    assign timed_inhibit = ~permit;
    assign instant_inhibit = ~permit;
endmodule

// *** sim/tb_neutral_directional_supervision.sv ***
`timescale 1ns/1ps
module tb_neutral_directional_supervision;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic signed [15:0] ar, ai, br, bi, cr, ci, vr, vi, qr, qi;
    logic permit, inhib, fwd, toc_blk, ioc_blk, e;
    int err_count, n_compared, k, x1, x2, x3, x4;
    real cs;

    nds_top #(.POL_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a_re(ar), .phase_a_im(ai), .phase_b_re(br), .phase_b_im(bi),
        .phase_c_re(cr), .phase_c_im(ci),
        .zero_sequence_voltage_re(vr), .zero_sequence_voltage_im(vi),
        .polarizing_current_re(qr), .polarizing_current_im(qi),
        .neutral_direction_permit(permit), .neutral_direction_inhibited(inhib),
        .neutral_direction_forward(fwd));
    nds_oc_partner p_u (.permit(permit), .timed_inhibit(toc_blk), .instant_inhibit(ioc_blk));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic real cosf(input int a, b, c, d);
        return (a * c + b * d) / $sqrt(real'(a * a + b * b) * real'(c * c + d * d));
    endfunction

    function automatic logic [31:0] cw(input logic en, rv, input logic [1:0] md,
                                       input logic fb, input logic signed [7:0] ta);
        return {16'h0, ta, 3'h0, fb, md, rv, en};
    endfunction

    task test_done;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Request held from setup until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task run(input int n, input logic signed [15:0] a_r, a_i, b_r, b_i, v_r, v_i, p_r, p_i,
             input logic [2:0] ex, mk, input string s,
             input logic signed [15:0] c_r = 16'sh0, c_i = 16'sh0);
        @(posedge pclk);
        ar <= a_r;
        ai <= a_i;
        br <= b_r;
        bi <= b_i;
        cr <= c_r;
        ci <= c_i;
        vr <= v_r;
        vi <= v_i;
        qr <= p_r;
        qi <= p_i;
        repeat (n) @(posedge pclk);
        #1;
        chk({29'h0, {permit, inhib, fwd} & mk}, {29'h0, ex & mk}, s);
        chk({30'h0, toc_blk, ioc_blk}, {30'h0, ~ex[2], ~ex[2]}, "partner");
    endtask

    initial begin
        #100000;
        err_count++;
        test_done();
    end

    initial begin
        {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        {ar, ai, br, bi, cr, ci, vr, vi, qr, qi} = '0;
        ce = 1'b1;
        seed = 32'hfe45;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, nds_pkg::CTRL_OFS, 0);
        chk(rd, 32'h0000d310, "ctrl reset");
        apb(0, nds_pkg::FLOOR_OFS, 0);
        chk(rd, 32'h32, "floor reset");
        apb(0, 8'h0c, 0);
        chk({31'h0, er}, 32'h1, "unmapped");
        // Block fallback while current is already present and voltage rises and settles
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_V, 0, 0));
        run(2, 100, 0, 0, 0, 0, 0, 100, 0, 3'b010, 3'h7, "v absent");
        run(2, 100, 0, 0, 0, -100, 0, 100, 0, 3'b010, 3'h7, "v settling");
        run(10, 100, 0, 0, 0, -100, 0, 100, 0, 3'b101, 3'h7, "v fwd");
        apb(0, nds_pkg::STATUS_OFS, 0);
        chk(rd, 32'h3d, "status");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_V, 0, 45));
        run(2, -500, 866, 0, 0, -100, 0, 100, 0, 3'b101, 3'h7, "ta pos");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_V, 0, -45));
        run(2, -500, 866, 0, 0, -100, 0, 100, 0, 3'b000, 3'h7, "ta neg");
        apb(1, nds_pkg::FLOOR_OFS, 200);
        run(2, -500, 866, 0, 0, -100, 0, 100, 0, 3'b010, 3'h7, "floor");
        apb(1, nds_pkg::FLOOR_OFS, 50);
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_EITHER, 0, 0));
        run(12, 100, 0, 0, 0, -100, 0, -100, 0, 3'b100, 3'b110, "either");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_BOTH, 0, 0));
        run(2, 100, 0, 0, 0, -100, 0, -100, 0, 3'b000, 3'b110, "both");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_I, 1, 0));
        run(2, 100, 0, 0, 0, 0, 0, 100, 0, 3'b101, 3'h7, "i fwd");
        run(2, 20, 0, 20, 0, 0, 0, 100, 0, 3'b101, 3'h7, "sum", 20, 0);
        run(2, 174, 985, 0, 0, 0, 0, 1000, 0, 3'b101, 3'h7, "i 80");
        run(2, 35, 999, 0, 0, 0, 0, 1000, 0, 3'b000, 3'h7, "i 88");
        run(2, 100, 0, 0, 0, 0, 0, 4, 0, 3'b110, 3'h7, "ip low");
        run(2, 49, 0, 0, 0, 0, 0, 100, 0, 3'b110, 3'h7, "op low");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_I, 0, 0));
        run(2, 100, 0, 0, 0, 0, 0, 4, 0, 3'b010, 3'h7, "fb block");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 1, nds_pkg::NDS_POL_I, 0, 0));
        run(2, -100, 0, 0, 0, 0, 0, 100, 0, 3'b100, 3'h7, "reverse");
        apb(1, nds_pkg::CTRL_OFS, cw(0, 0, nds_pkg::NDS_POL_I, 1, 0));
        run(2, 100, 0, 0, 0, 0, 0, 4, 0, 3'b000, 3'h7, "disabled");
        apb(1, nds_pkg::CTRL_OFS, cw(1, 0, nds_pkg::NDS_POL_I, 0, 0));
        for (k = 0; k < 30; k++) begin
            seed = xs(seed);
            x1 = int'(seed[10:0]) - 1024;
            x2 = int'(seed[21:11]) - 1024;
            seed = xs(seed);
            x3 = int'(seed[10:0]) - 1024;
            x4 = int'(seed[21:11]) - 1024;
            if (x1 * x1 + x2 * x2 < 10000 || x3 * x3 + x4 * x4 < 400) continue;
            cs = cosf(x1, x2, x3, x4);
            if (cs > 0.0772 && cs < 0.0972) continue;
            e = cs > 0.0872;
            run(2, 16'(x1), 16'(x2), 0, 0, 0, 0, 16'(x3), 16'(x4),
                {e, 1'b0, e}, 3'h7, "random");
        end
        test_done();
    end
endmodule
